// ===== rfm_pkg.sv
// constants, register map and carrier types of the receive fec link status monitor
package rfm_pkg;
	localparam int          LANES        = 1;
	localparam int          AXI_AW       = 16;
	// register indices; byte address is four times the index
	localparam logic [13:0] IDX_REV      = 14'h0D00;
	localparam logic [13:0] IDX_ID0      = 14'h0D01;
	localparam logic [13:0] IDX_ID1      = 14'h0D02;
	localparam logic [13:0] IDX_ID2      = 14'h0D03;
	localparam logic [13:0] IDX_CTRL     = 14'h0D04;
	localparam logic [13:0] IDX_ALIGN    = 14'h0D05;
	localparam logic [13:0] IDX_FIXED    = 14'h0D06;
	localparam logic [13:0] IDX_UNFIXED  = 14'h0D07;
	localparam logic [13:0] IDX_CLKLOCK  = 14'h0321;
	localparam logic [13:0] IDX_FRMERR   = 14'h0323;
	localparam logic [13:0] IDX_FRMCLR   = 14'h0324;
	localparam logic [13:0] IDX_PCSALIGN = 14'h0326;
	localparam logic [13:0] IDX_FAULT    = 14'h0308;
	localparam logic [13:0] IDX_FLAGSEL  = 14'h0330;
	localparam logic [13:0] IDX_FLAGVAL  = 14'h0331;
	localparam logic [13:0] IDX_CFG      = 14'h0332;
	localparam logic [13:0] IDX_IRQSTAT  = 14'h0340;
	localparam logic [13:0] IDX_IRQMASK  = 14'h0341;
	// identity words; values are arbitrary
	localparam logic [31:0] REV_ID       = 32'h0000_0001;
	localparam logic [31:0] IDENT0       = 32'h1111_1111;
	localparam logic [31:0] IDENT1       = 32'h2222_2222;
	localparam logic [31:0] IDENT2       = 32'h3333_3333;
	// field positions
	localparam int          B_BYPASS     = 0;
	localparam int          B_RESYNC     = 4;
	localparam int          B_LOCK       = 0;
	localparam int          B_CLR        = 0;
	localparam int          B_LFEN       = 0;
	localparam int          B_ALIGNED    = 0;
	localparam int          B_LFAULT     = 0;
	localparam int          B_FSEL       = 0;
	localparam int          IRQ_LOS      = 0;
	localparam int          IRQ_AMLOST   = 1;
	localparam int          IRQ_UNFIX    = 2;
	localparam int          IRQ_CRC      = 3;
	localparam int          IRQ_W        = 4;
	// reset values
	localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
	localparam logic [31:0] CNT_MAX      = 32'hFFFF_FFFF;
	localparam logic        RST_LFEN     = 1'h1;
	localparam logic [1:0]  RESP_OK      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	// receive soft reset pulse length
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          SOFT_RST_NS   = 100;
	localparam int          SOFT_RST_CYC  = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  SOFT_RST_LEN  = 8'(SOFT_RST_CYC < 1 ? 1 : SOFT_RST_CYC);
	// 66-bit block: sync header, block type, eight error characters
	localparam logic [65:0] ERR_BLK = {{8{7'h1E}}, 8'h1E, 2'h2};

	typedef struct packed {
		logic [65:0] blk;
		logic        last;
		logic        err;
	} rfm_blk_t;
endpackage : rfm_pkg

// ===== rfm_tx_err_ins.sv
// transmit stage that swaps a flagged packet's closing block for the error block
`timescale 1ns/1ps
module rfm_tx_err_ins (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            in_valid,
	output logic                 in_ready,
	input  wire rfm_pkg::rfm_blk_t in_blk,
	output logic                 out_valid,
	input  wire logic            out_ready,
	output rfm_pkg::rfm_blk_t    out_blk
);
	logic              out_valid_q;
	rfm_pkg::rfm_blk_t out_q;

	// single register stage: taking only when empty keeps ready a flop at half rate
	assign in_ready  = !out_valid_q;
	assign out_valid = out_valid_q;
	assign out_blk   = out_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_valid_q <= 1'b0;
			out_q       <= '0;
		end
		else if (in_valid && !out_valid_q)
		begin
			out_valid_q <= 1'b1;
			out_q       <= in_blk;
			if (in_blk.last && in_blk.err)
				out_q.blk <= rfm_pkg::ERR_BLK; // [RQ17]
		end
		else if (out_ready)
			out_valid_q <= 1'b0;
	end

	a_err_blk_out: assert property (@(posedge clk) disable iff (rst)
		in_valid && in_ready && in_blk.last && in_blk.err |=> out_valid && out_blk.blk == rfm_pkg::ERR_BLK)
		else $error("flagged end block not replaced"); // [RQ17]
	a_clean_pass: assert property (@(posedge clk) disable iff (rst)
		in_valid && in_ready && !in_blk.err |=> out_blk.blk == $past(in_blk.blk))
		else $error("clean block altered"); // [RQ17]
endmodule : rfm_tx_err_ins

// ===== rfm_rx_err_det.sv
// receive check that flags a frame holding an error block or a block with its err flag set
`timescale 1ns/1ps
module rfm_rx_err_det (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            in_valid,
	input  wire rfm_pkg::rfm_blk_t in_blk,
	output logic                 crc_err
);
	logic corrupt_q;
	logic crc_err_q;
	logic hit;

	assign hit     = in_blk.err || (in_blk.blk == rfm_pkg::ERR_BLK);
	assign crc_err = crc_err_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			corrupt_q <= 1'b0;
			crc_err_q <= 1'b0;
		end
		else
		begin
			crc_err_q <= in_valid && in_blk.last && (corrupt_q || hit); // [RQ18]
			if (in_valid)
				corrupt_q <= !in_blk.last && (corrupt_q || hit);
		end
	end

	a_crc_on_eblk: assert property (@(posedge clk) disable iff (rst)
		in_valid && in_blk.last && in_blk.blk == rfm_pkg::ERR_BLK |=> crc_err)
		else $error("error block frame not reported"); // [RQ18]
endmodule : rfm_rx_err_det

// ===== rfm_link_monitor.sv
// top of the receive fec link status monitor: register bank, link state and stream stages
// Function
// [RQ1] bypass bit stops fec correction while the decoder stays in the path
// [RQ2] writing one to resync bit restarts marker sync, then the bit self-clears
// [RQ3] alignment status bit 0 reads marker lock; other bits read zero
// [RQ4] 32-bit corrected codeword count saturates and clears when read
// [RQ5] 32-bit uncorrected codeword count saturates and clears when read
// [RQ6] writing one then zero to frame error clear restarts tally from zero
// [RQ7] after a clear the tally reads zero while every lane holds word lock
// [RQ8] clock lock register has one bit per lane, high while that lane locked
// [RQ9] pma flag value shows tx or rx fifo flags chosen by flag select
// [RQ10] loss of signal drops the receive pcs ready output
// [RQ11] loss of signal leaves the transmit path untouched
// [RQ12] pcs aligned status bit 0 follows the receive pcs ready output
// [RQ13] with link fault enabled, loss of signal raises local fault
// [RQ14] link fault register bit 0 mirrors the local fault output
// [RQ15] loss of signal starts the receive soft reset pulse
// [RQ16] client flags an error in the same cycle as packet end
// [RQ17] a flagged packet's end block goes out as the error block
// [RQ18] receive side reports a frame with an error block as crc error
// [RQ19] reserved bits read zero and ignore writes
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module rfm_link_monitor (
	input  wire logic                 CLK,
	input  wire logic                 SYS_RST,
	input  wire logic                 S_AXI_AWVALID,
	output logic                      S_AXI_AWREADY,
	input  wire logic [15:0]          S_AXI_AWADDR,
	input  wire logic                 S_AXI_WVALID,
	output logic                      S_AXI_WREADY,
	input  wire logic [31:0]          S_AXI_WDATA,
	input  wire logic [3:0]           S_AXI_WSTRB,
	output logic                      S_AXI_BVALID,
	input  wire logic                 S_AXI_BREADY,
	output logic [1:0]                S_AXI_BRESP,
	input  wire logic                 S_AXI_ARVALID,
	output logic                      S_AXI_ARREADY,
	input  wire logic [15:0]          S_AXI_ARADDR,
	output logic                      S_AXI_RVALID,
	input  wire logic                 S_AXI_RREADY,
	output logic [31:0]               S_AXI_RDATA,
	output logic [1:0]                S_AXI_RRESP,
	input  wire logic                 RX_SIGNAL_OK,
	input  wire logic                 FEC_AM_LOCK,
	input  wire logic                 FEC_CW_FIXED,
	input  wire logic                 FEC_CW_UNFIXED,
	input  wire logic [0:0]           LANE_WORD_LOCK,
	input  wire logic [0:0]           LANE_CLOCK_LOCK,
	input  wire logic [3:0]           PMA_FIFO_FLAGS,
	output logic                      FEC_BYPASS,
	output logic                      FEC_RESYNC,
	output logic                      RX_PCS_READY,
	output logic                      LOCAL_FAULT,
	output logic                      SOFT_RX_RST,
	output logic                      IRQ,
	input  wire logic                 TX_IN_VALID,
	output logic                      TX_IN_READY,
	input  wire rfm_pkg::rfm_blk_t    TX_IN,
	output logic                      TX_OUT_VALID,
	input  wire logic                 TX_OUT_READY,
	output rfm_pkg::rfm_blk_t         TX_OUT,
	input  wire logic                 RX_IN_VALID,
	input  wire rfm_pkg::rfm_blk_t    RX_IN,
	output logic                      RX_CRC_ERR
);
	////////////////////////////////////////////////////////////////////////////////
	// register bus
	logic                      aw_hold_q;
	logic                      w_hold_q;
	logic [13:0]               aw_idx_q;
	logic [31:0]               w_data_q;
	logic [3:0]                w_strb_q;
	logic                      bvalid_q;
	logic [1:0]                bresp_q;
	logic                      rvalid_q;
	logic [31:0]               rdata_q;
	logic [1:0]                rresp_q;
	logic                      wr_go;
	logic                      rd_go;
	logic [13:0]               rd_idx;
	logic [31:0]               rd_d;
	logic                      rd_hit;
	logic                      wr_hit;

	assign S_AXI_AWREADY = !aw_hold_q && !bvalid_q;
	assign S_AXI_WREADY  = !w_hold_q && !bvalid_q;
	assign S_AXI_BVALID  = bvalid_q;
	assign S_AXI_BRESP   = bresp_q;
	assign S_AXI_ARREADY = !rvalid_q;
	assign S_AXI_RVALID  = rvalid_q;
	assign S_AXI_RDATA   = rdata_q;
	assign S_AXI_RRESP   = rresp_q;
	assign wr_go         = aw_hold_q && w_hold_q && !bvalid_q;
	assign rd_go         = S_AXI_ARVALID && !rvalid_q;
	assign rd_idx        = S_AXI_ARADDR[15:2];

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_idx_q  <= '0;
			w_data_q  <= rfm_pkg::RST_ZERO;
			w_strb_q  <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= rfm_pkg::RESP_OK;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_hold_q <= 1'b1;
				aw_idx_q  <= S_AXI_AWADDR[15:2];
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_hold_q <= 1'b1;
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
			end
			if (wr_go)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? rfm_pkg::RESP_OK : rfm_pkg::RESP_SLVERR;
			end
			else if (S_AXI_BREADY)
				bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= rfm_pkg::RST_ZERO;
			rresp_q  <= rfm_pkg::RESP_OK;
		end
		else if (rd_go)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_d;
			rresp_q  <= rd_hit ? rfm_pkg::RESP_OK : rfm_pkg::RESP_SLVERR;
		end
		else if (S_AXI_RREADY)
			rvalid_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// control registers; all writable bits sit in byte lane 0
	logic                      wr_lane0;
	logic                      bypass_q;
	logic                      resync_q;
	logic                      frm_clr_q;
	logic                      flag_sel_q;
	logic                      lf_en_q;
	logic [rfm_pkg::IRQ_W-1:0] irq_mask_q;

	assign wr_lane0   = wr_go && w_strb_q[0];
	assign wr_hit     = aw_idx_q inside {rfm_pkg::IDX_REV, rfm_pkg::IDX_ID0, rfm_pkg::IDX_ID1,
		rfm_pkg::IDX_ID2, rfm_pkg::IDX_CTRL, rfm_pkg::IDX_ALIGN, rfm_pkg::IDX_FIXED,
		rfm_pkg::IDX_UNFIXED, rfm_pkg::IDX_CLKLOCK, rfm_pkg::IDX_FRMERR, rfm_pkg::IDX_FRMCLR,
		rfm_pkg::IDX_PCSALIGN, rfm_pkg::IDX_FAULT, rfm_pkg::IDX_FLAGSEL, rfm_pkg::IDX_FLAGVAL,
		rfm_pkg::IDX_CFG, rfm_pkg::IDX_IRQSTAT, rfm_pkg::IDX_IRQMASK};
	assign FEC_BYPASS = bypass_q;
	assign FEC_RESYNC = resync_q;

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			bypass_q   <= 1'b0;
			resync_q   <= 1'b0;
			frm_clr_q  <= 1'b0;
			flag_sel_q <= 1'b0;
			lf_en_q    <= rfm_pkg::RST_LFEN;
			irq_mask_q <= '0;
		end
		else
		begin
			// the restart is issued by the one cycle the bit is high, so it clears next cycle
			resync_q <= 1'b0; // [RQ2]
			if (wr_lane0)
			begin
				case (aw_idx_q)
					rfm_pkg::IDX_CTRL:
					begin
						bypass_q <= w_data_q[rfm_pkg::B_BYPASS]; // [RQ1]
						resync_q <= w_data_q[rfm_pkg::B_RESYNC]; // [RQ2]
					end
					rfm_pkg::IDX_FRMCLR: frm_clr_q  <= w_data_q[rfm_pkg::B_CLR]; // [RQ6]
					rfm_pkg::IDX_FLAGSEL: flag_sel_q <= w_data_q[rfm_pkg::B_FSEL];
					rfm_pkg::IDX_CFG: lf_en_q    <= w_data_q[rfm_pkg::B_LFEN];
					rfm_pkg::IDX_IRQMASK: irq_mask_q <= w_data_q[rfm_pkg::IRQ_W-1:0];
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// codeword counters, saturating, cleared by a read; a count in the read cycle survives
	logic [1:0]                cnt_ev;
	logic [1:0]                cnt_rd;
	logic [31:0]               cnt_q [2];

	assign cnt_ev = {FEC_CW_UNFIXED, FEC_CW_FIXED && !bypass_q};
	assign cnt_rd = {rd_go && rd_idx == rfm_pkg::IDX_UNFIXED, rd_go && rd_idx == rfm_pkg::IDX_FIXED};

	for (genvar c = 0; c < 2; c++)
	begin : g_cnt
		always_ff @(posedge CLK or posedge SYS_RST)
		begin
			if (SYS_RST)
				cnt_q[c] <= rfm_pkg::RST_ZERO;
			else if (cnt_rd[c])
				cnt_q[c] <= {31'h0, cnt_ev[c]}; // [RQ4] [RQ5]
			else if (cnt_ev[c] && cnt_q[c] != rfm_pkg::CNT_MAX)
				cnt_q[c] <= cnt_q[c] + 32'h1; // [RQ4] [RQ5]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// link state and loss of signal reaction; transmit stages never see these
	logic                      los;
	logic                      los_q;
	logic                      ready_q;
	logic                      fault_q;
	logic                      srst_q;
	logic [7:0]                srst_cnt_q;
	logic [rfm_pkg::LANES-1:0] frame_error_tally_q;

	assign los          = !RX_SIGNAL_OK;
	assign RX_PCS_READY = ready_q;
	assign LOCAL_FAULT  = fault_q;
	assign SOFT_RX_RST  = srst_q;

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			los_q   <= 1'b0;
			ready_q <= 1'b0;
			fault_q <= 1'b0;
		end
		else
		begin
			los_q   <= los;
			ready_q <= FEC_AM_LOCK && !los && !srst_q; // [RQ10] [RQ11]
			fault_q <= lf_en_q && los; // [RQ13]
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			srst_q     <= 1'b0;
			srst_cnt_q <= '0;
		end
		else if (los && !los_q)
		begin
			srst_q     <= 1'b1; // [RQ15]
			srst_cnt_q <= rfm_pkg::SOFT_RST_LEN;
		end
		else if (srst_cnt_q != 8'h0)
			srst_cnt_q <= srst_cnt_q - 8'h1;
		else
			srst_q <= 1'b0;
	end

	// a lane losing word lock marks the tally; the mark beats a held clear
	for (genvar l = 0; l < rfm_pkg::LANES; l++)
	begin : g_lane
		always_ff @(posedge CLK or posedge SYS_RST)
		begin
			if (SYS_RST)
				frame_error_tally_q[l] <= 1'b0;
			else if (!LANE_WORD_LOCK[l])
				frame_error_tally_q[l] <= 1'b1; // [RQ7]
			else if (frm_clr_q)
				frame_error_tally_q[l] <= 1'b0; // [RQ6]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status, cleared by a read; a new event in the read cycle stays set
	logic [rfm_pkg::IRQ_W-1:0] irq_ev;
	logic [rfm_pkg::IRQ_W-1:0] irq_st_q;
	logic                      irq_q;
	logic                      crc_err;
	logic                      ready_prev_q;

	assign irq_ev = {crc_err, FEC_CW_UNFIXED, ready_prev_q && !ready_q, los && !los_q};
	assign IRQ    = irq_q;

	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			irq_st_q     <= '0;
			irq_q        <= 1'b0;
			ready_prev_q <= 1'b0;
		end
		else
		begin
			ready_prev_q <= ready_q;
			irq_q        <= |(irq_st_q & irq_mask_q);
			if (rd_go && rd_idx == rfm_pkg::IDX_IRQSTAT)
				irq_st_q <= irq_ev;
			else
				irq_st_q <= irq_st_q | irq_ev;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux; unnamed bits stay zero
	always_comb
	begin
		rd_d   = rfm_pkg::RST_ZERO; // [RQ19]
		rd_hit = 1'b1;
		case (rd_idx)
			rfm_pkg::IDX_REV: rd_d = rfm_pkg::REV_ID;
			rfm_pkg::IDX_ID0: rd_d = rfm_pkg::IDENT0;
			rfm_pkg::IDX_ID1: rd_d = rfm_pkg::IDENT1;
			rfm_pkg::IDX_ID2: rd_d = rfm_pkg::IDENT2;
			rfm_pkg::IDX_CTRL:
			begin
				rd_d[rfm_pkg::B_BYPASS] = bypass_q;
				rd_d[rfm_pkg::B_RESYNC] = resync_q; // [RQ2]
			end
			rfm_pkg::IDX_ALIGN: rd_d[rfm_pkg::B_LOCK] = FEC_AM_LOCK; // [RQ3]
			rfm_pkg::IDX_FIXED: rd_d = cnt_q[0]; // [RQ4]
			rfm_pkg::IDX_UNFIXED: rd_d = cnt_q[1]; // [RQ5]
			rfm_pkg::IDX_CLKLOCK: rd_d[rfm_pkg::LANES-1:0] = LANE_CLOCK_LOCK; // [RQ8]
			rfm_pkg::IDX_FRMERR: rd_d[rfm_pkg::LANES-1:0] = frame_error_tally_q; // [RQ7]
			rfm_pkg::IDX_FRMCLR: rd_d[rfm_pkg::B_CLR] = frm_clr_q;
			rfm_pkg::IDX_PCSALIGN: rd_d[rfm_pkg::B_ALIGNED] = ready_q; // [RQ12]
			rfm_pkg::IDX_FAULT: rd_d[rfm_pkg::B_LFAULT] = fault_q; // [RQ14]
			rfm_pkg::IDX_FLAGSEL: rd_d[rfm_pkg::B_FSEL] = flag_sel_q;
			rfm_pkg::IDX_FLAGVAL: rd_d[1:0] = flag_sel_q ? PMA_FIFO_FLAGS[3:2] : PMA_FIFO_FLAGS[1:0]; // [RQ9]
			rfm_pkg::IDX_CFG: rd_d[rfm_pkg::B_LFEN] = lf_en_q;
			rfm_pkg::IDX_IRQSTAT: rd_d[rfm_pkg::IRQ_W-1:0] = irq_st_q;
			rfm_pkg::IDX_IRQMASK: rd_d[rfm_pkg::IRQ_W-1:0] = irq_mask_q;
			default: rd_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// stream stages
	rfm_tx_err_ins u_tx (
		.clk       (CLK),
		.rst       (SYS_RST),
		.in_valid  (TX_IN_VALID),
		.in_ready  (TX_IN_READY),
		.in_blk    (TX_IN), // [RQ16]
		.out_valid (TX_OUT_VALID),
		.out_ready (TX_OUT_READY),
		.out_blk   (TX_OUT)
	);

	rfm_rx_err_det u_rx (
		.clk      (CLK),
		.rst      (SYS_RST),
		.in_valid (RX_IN_VALID),
		.in_blk   (RX_IN),
		.crc_err  (crc_err)
	);

	assign RX_CRC_ERR = crc_err;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_ready_drops: assert property (@(posedge CLK) disable iff (SYS_RST)
		los |=> !RX_PCS_READY) else $error("ready held through loss of signal"); // [RQ10]
	a_aligned_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
		rd_go && rd_idx == rfm_pkg::IDX_PCSALIGN |=> S_AXI_RDATA == {31'h0, $past(ready_q)})
		else $error("aligned bit differs from ready"); // [RQ12]
	a_fault_set: assert property (@(posedge CLK) disable iff (SYS_RST)
		los && lf_en_q |=> LOCAL_FAULT) else $error("no local fault on loss"); // [RQ13]
	a_fault_read: assert property (@(posedge CLK) disable iff (SYS_RST)
		rd_go && rd_idx == rfm_pkg::IDX_FAULT |=> S_AXI_RDATA[0] == $past(fault_q))
		else $error("fault bit differs from output"); // [RQ14]
	a_soft_rst: assert property (@(posedge CLK) disable iff (SYS_RST)
		los && !los_q |=> SOFT_RX_RST [*8]) else $error("soft reset pulse too short"); // [RQ15]
	a_resync_pulse: assert property (@(posedge CLK) disable iff (SYS_RST)
		FEC_RESYNC |=> !FEC_RESYNC) else $error("resync bit did not clear"); // [RQ2]
	a_cnt_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
		cnt_rd[0] && !cnt_ev[0] |=> cnt_q[0] == 32'h0) else $error("fixed count not cleared"); // [RQ4]
	a_cnt_sat: assert property (@(posedge CLK) disable iff (SYS_RST)
		cnt_q[1] == rfm_pkg::CNT_MAX && !cnt_rd[1] |=> cnt_q[1] == rfm_pkg::CNT_MAX)
		else $error("unfixed count wrapped"); // [RQ5]
	a_bypass_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
		bypass_q && !cnt_rd[0] |=> $stable(cnt_q[0])) else $error("correction counted in bypass"); // [RQ1]
	a_frm_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
		frm_clr_q && &LANE_WORD_LOCK |=> frame_error_tally_q == '0) else $error("tally not cleared"); // [RQ6] [RQ7]
	a_align_read: assert property (@(posedge CLK) disable iff (SYS_RST)
		rd_go && rd_idx == rfm_pkg::IDX_ALIGN |=> S_AXI_RDATA[31:1] == 31'h0)
		else $error("reserved align bits set"); // [RQ3] [RQ19]
endmodule : rfm_link_monitor

// ===== rfm_client_model.sv
// client model: sends three-block tx packets and sinks the tx output with stalls
`timescale 1ns/1ps
module rfm_client_model (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         go,
	input  wire logic         bad,
	input  wire logic         in_ready,
	output logic              in_valid,
	output rfm_pkg::rfm_blk_t in_blk,
	output logic              out_ready
);
	logic [2:0] n_q;
	logic [1:0] t_q;
	////////////////////////////////////////
	// stall one cycle in four so the output stage must hold its block
	always_ff @(posedge clk or posedge rst)
		if (rst)
			t_q <= 2'h0;
		else
			t_q <= t_q + 2'h1;
	assign out_ready = t_q != 2'h3;
	////////////////////////////////////////
	// blocks counted down; released lines show the inverse, never a stale block
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			n_q      <= 3'h0;
			in_valid <= 1'b0;
			in_blk   <= '0;
		end
		else if (go && !in_valid)
		begin
			n_q      <= 3'h3;
			in_valid <= 1'b1;
			in_blk   <= {66'h3, 1'b0, 1'b0};
		end
		else if (in_valid && in_ready)
		begin
			n_q      <= n_q - 3'h1;
			in_valid <= n_q != 3'h1;
			in_blk   <= n_q == 3'h1 ? ~in_blk : {66'(n_q - 3'h1), n_q == 3'h2, bad && n_q == 3'h2};
		end
endmodule : rfm_client_model

// ===== rx_fec_link_status_monitor_test.sv
// self-checking bench for the receive fec link status monitor
`timescale 1ns/1ps
module rx_fec_link_status_monitor_test;
	typedef struct packed {logic [13:0] i; logic [31:0] d; logic [1:0] r;} rfm_row_t;
	logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, sok = 1, aml = 1, cwf = 0, cwu = 0;
	logic go = 0, bad = 0, rxv = 0, awr, wr, bv, arr, rv, byp, rsy, rdy, lf, srst, irq, tiv, tir, tov, tor, crc;
	logic [15:0]       awa = 0, ara = 0;
	logic [31:0]       wd = 0, rd, q;
	logic [1:0]        bresp, rresp, r;
	logic [0:0]        wl = 1, cl = 1;
	logic [3:0]        ff = 4'h6;
	logic [65:0]       lastb;
	rfm_pkg::rfm_blk_t ti, to, rxi = '0;
	int                n_mismatch = 0, tests_run = 0, n_rsy = 0, n_crc = 0, n_last = 0;
	rfm_row_t rows [13] = '{'{rfm_pkg::IDX_REV, rfm_pkg::REV_ID, 2'h0}, '{rfm_pkg::IDX_ID0, rfm_pkg::IDENT0, 2'h0},
		'{rfm_pkg::IDX_ID1, rfm_pkg::IDENT1, 2'h0}, '{rfm_pkg::IDX_ID2, rfm_pkg::IDENT2, 2'h0},
		'{rfm_pkg::IDX_CTRL, 0, 2'h0}, '{rfm_pkg::IDX_ALIGN, 1, 2'h0}, '{rfm_pkg::IDX_FIXED, 0, 2'h0},
		'{rfm_pkg::IDX_UNFIXED, 0, 2'h0}, '{rfm_pkg::IDX_CFG, 1, 2'h0}, '{rfm_pkg::IDX_CLKLOCK, 1, 2'h0},
		'{rfm_pkg::IDX_PCSALIGN, 1, 2'h0}, '{rfm_pkg::IDX_FLAGVAL, 2, 2'h0}, '{14'h0100, 0, 2'h2}};
	rfm_pkg::rfm_blk_t rxs [4] = '{{66'h5, 2'h0}, {rfm_pkg::ERR_BLK, 2'h2}, {66'h6, 2'h0}, {66'h7, 2'h2}};

	always #5 clk = ~clk;

	rfm_link_monitor u_rfm_link_monitor (.CLK(clk), .SYS_RST(rst), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp),
		.RX_SIGNAL_OK(sok), .FEC_AM_LOCK(aml), .FEC_CW_FIXED(cwf), .FEC_CW_UNFIXED(cwu), .LANE_WORD_LOCK(wl),
		.LANE_CLOCK_LOCK(cl), .PMA_FIFO_FLAGS(ff), .FEC_BYPASS(byp), .FEC_RESYNC(rsy), .RX_PCS_READY(rdy),
		.LOCAL_FAULT(lf), .SOFT_RX_RST(srst), .IRQ(irq), .TX_IN_VALID(tiv), .TX_IN_READY(tir), .TX_IN(ti),
		.TX_OUT_VALID(tov), .TX_OUT_READY(tor), .TX_OUT(to), .RX_IN_VALID(rxv), .RX_IN(rxi), .RX_CRC_ERR(crc));
	rfm_client_model u_rfm_client_model (.clk(clk), .rst(rst), .go(go), .bad(bad), .in_ready(tir),
		.in_valid(tiv), .in_blk(ti), .out_ready(tor));

	// pulses are counted here since they stand for a single cycle only
	always @(posedge clk)
	begin
		n_rsy <= n_rsy + int'(rsy === 1'b1);
		n_crc <= n_crc + int'(crc === 1'b1);
		if (tov === 1'b1 && tor && to.last)
		begin
			lastb  <= to.blk;
			n_last <= n_last + 1;
		end
	end
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [65:0] e, input logic [65:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	// values are sampled at the falling edge, which is what the next rising edge sees
	task automatic bus(input bit w, input logic [13:0] i, input logic [31:0] d);
		logic a, b, v;
		v = 0;
		@(posedge clk);
		{awv, wv, br, arv, rr} <= {w, w, w, !w, !w};
		{awa, ara, wd} <= {i, 2'h0, i, 2'h0, d};
		while (!v)
		begin
			@(negedge clk);
			a = awv && awr || arv && arr;
			b = wv && wr;
			v = w ? bv : rv;
			{q, r} = {rd, w ? bresp : rresp};
			@(posedge clk);
			if (a) {awv, arv} <= 2'h0;
			if (b) wv <= 1'b0;
			if (v) {br, rr} <= 2'h0;
		end
	endtask : bus

	task automatic rdc(input logic [13:0] i, input logic [31:0] e);
		bus(0, i, 0);
		chk("read data", e, q);
	endtask : rdc

	task automatic close_out;
		if (n_mismatch == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	////////////////////////////////////////
	initial
	begin
		#100000;
		n_mismatch++;
		close_out;
	end

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 0;
		repeat (4) @(posedge clk);
		foreach (rows[k])
		begin
			rdc(rows[k].i, rows[k].d);
			chk("read resp", rows[k].r, r);
		end
		bus(1, rfm_pkg::IDX_CTRL, 32'hFFFF_FFFF);
		repeat (2) @(negedge clk);
		chk("bypass", 1, byp);
		chk("resync pulses", 1, n_rsy);
		rdc(rfm_pkg::IDX_CTRL, 1);
		@(posedge clk) cwf <= 1;
		@(posedge clk) cwf <= 0;
		rdc(rfm_pkg::IDX_FIXED, 0);
		bus(1, rfm_pkg::IDX_CTRL, 0);
		@(posedge clk) {cwf, cwu} <= 2'h3;
		@(posedge clk) cwu <= 0;
		@(posedge clk) cwf <= 0;
		rdc(rfm_pkg::IDX_FIXED, 2);
		rdc(rfm_pkg::IDX_FIXED, 0);
		rdc(rfm_pkg::IDX_UNFIXED, 1);
		rdc(rfm_pkg::IDX_UNFIXED, 0);
		@(negedge clk);
		chk("masked irq", 0, irq);
		rdc(rfm_pkg::IDX_IRQSTAT, 4);
		@(posedge clk) wl <= 0;
		@(posedge clk) wl <= 1;
		rdc(rfm_pkg::IDX_FRMERR, 1);
		bus(1, rfm_pkg::IDX_FRMCLR, 1);
		bus(1, rfm_pkg::IDX_FRMCLR, 0);
		rdc(rfm_pkg::IDX_FRMERR, 0);
		bus(1, rfm_pkg::IDX_FLAGSEL, 1);
		rdc(rfm_pkg::IDX_FLAGVAL, 1);
		bus(1, rfm_pkg::IDX_IRQMASK, 1);
		@(posedge clk) {sok, go, bad} <= 3'h3;
		@(posedge clk) go <= 0;
		repeat (4) @(negedge clk);
		chk("pcs ready", 0, rdy);
		chk("local fault", 1, lf);
		chk("soft reset", 1, srst);
		chk("irq", 1, irq);
		for (int k = 0; k < 60 && n_last == 0; k++) @(posedge clk);
		chk("tx end block", rfm_pkg::ERR_BLK, lastb);
		rdc(rfm_pkg::IDX_PCSALIGN, 0);
		rdc(rfm_pkg::IDX_FAULT, 1);
		rdc(rfm_pkg::IDX_IRQSTAT, 3);
		@(negedge clk);
		chk("cleared irq", 0, irq);
		@(posedge clk) {sok, go, bad} <= 3'h6;
		@(posedge clk) go <= 0;
		for (int k = 0; k < 60 && n_last == 1; k++) @(posedge clk);
		chk("tx end block", 66'h1, lastb);
		foreach (rxs[k])
			@(posedge clk) {rxv, rxi} <= {1'b1, rxs[k]};
		@(posedge clk) {rxv, rxi} <= {1'b0, ~rxi};
		repeat (3) @(negedge clk);
		chk("crc errors", 1, n_crc);
		bus(1, 14'h0100, 0);
		chk("write resp", 2, r);
		bus(1, rfm_pkg::IDX_CTRL, 1);
		chk("write resp", 0, r);
		@(posedge clk) rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk("bypass after reset", 0, byp);
		rdc(rfm_pkg::IDX_CFG, 1);
		rdc(rfm_pkg::IDX_PCSALIGN, 1);
		close_out;
	end
endmodule : rx_fec_link_status_monitor_test
